//--- core/setpoint_alarm_pkg.sv
package setpoint_alarm_pkg;

  localparam int NUM_SP_DEF = 2;
  localparam int MEAS_W     = 18;
  localparam int HYS_W      = 16;
  localparam int DLY_W      = 13;
  localparam int ADDR_W     = 8;

  // Limits of the programmable quantities.
  localparam logic signed [MEAS_W-1:0] SP_MIN  = -18'sh04e1f;
  localparam logic signed [MEAS_W-1:0] SP_MAX  = 18'sh1869f;
  localparam logic [HYS_W-1:0]         HYS_MIN = 16'h0001;
  localparam logic [HYS_W-1:0]         HYS_MAX = 16'hea5f;
  localparam logic [DLY_W-1:0]         DLY_MAX = 13'h176f;

  // Time base.
  localparam int CLK_MHZ    = 200;
  localparam int TICK_S     = 1;
  localparam int SEC_CYCLES = TICK_S * CLK_MHZ * 1000000;

  // Register offsets.
  localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] SER_RST_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] SP_BASE_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] SP_STRIDE   = 8'h20;
  localparam logic [ADDR_W-1:0] CFG_OFS     = 8'h00;
  localparam logic [ADDR_W-1:0] VAL_OFS     = 8'h04;
  localparam logic [ADDR_W-1:0] HYS_OFS     = 8'h08;
  localparam logic [ADDR_W-1:0] ON_DLY_OFS  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_DLY_OFS = 8'h10;

  // Reset values.
  localparam logic [7:0]  CFG_RST = 8'h00;
  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    high_trip_balanced,
    low_trip_balanced,
    high_trip_unbalanced,
    low_trip_unbalanced
  } action_t;

  typedef enum logic [1:0] {
    automatic_mode,
    latch_immediate_mode,
    latch_deferred_mode
  } reset_mode_t;

  typedef struct packed {
    logic        colourChange;
    logic        standby;
    logic        rstWithDisp;
    reset_mode_t resetMode;
    action_t     action;
    logic        enable;
  } sp_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_t;

endpackage

//--- core/setpoint_alarm_output.sv
// Function
// - Disabled second setpoint keeps output off.
// - Four actions: high/low, balanced/unbalanced.
// - Signed setpoint from -19999 to 99999.
// - Hysteresis 1 to 59999 shapes thresholds.
// - Unbalanced band below high, above low.
// - On-delay 0 to 5999 seconds.
// - Off-delay 0 to 5999 seconds.
// - Automatic mode releases at release point.
// - Automatic: manual reset forces off now.
// - Immediate latch holds until reset.
// - Immediate latch reset off until re-trip.
// - Latched output comes up off.
// - Deferred latch reset waits for release.
// - Pending deferred reset lost on power.
// - Display reset also resets output.
// - Only if assigned and input shown.
// - Standby holds output off until trip.
// - After standby, output acts normally.
// - Backlight colour follows output state.
// - Setpoint count set by output card.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module setpoint_alarm_output #(
  parameter int NUM_SP     = setpoint_alarm_pkg::NUM_SP_DEF,
  parameter int SEC_CYCLES = setpoint_alarm_pkg::SEC_CYCLES
) (
  input  wire logic                                sys_clk,
  input  wire logic                                rst_n,
  input  wire logic                                ce,
  input  wire setpoint_alarm_pkg::axil_req_t       axiReq,
  output setpoint_alarm_pkg::axil_rsp_t            axiRsp,
  input  wire logic signed [setpoint_alarm_pkg::MEAS_W-1:0] measValue,
  input  wire logic                                inputShown,
  input  wire logic                                resetKeyPin,
  input  wire logic                                userInputPin,
  output logic [NUM_SP-1:0]                        spOut,
  output logic                                     backlightRed
);
  import setpoint_alarm_pkg::*;

  localparam int SW = $clog2(SEC_CYCLES + 1);

  // Register state.
  sp_cfg_t                  cfgQ    [NUM_SP];
  logic signed [MEAS_W-1:0] valQ    [NUM_SP];
  logic [HYS_W-1:0]         hysQ    [NUM_SP];
  logic [DLY_W-1:0]         onDlyQ  [NUM_SP];
  logic [DLY_W-1:0]         offDlyQ [NUM_SP];
  logic [2:0]               ctrlQ;
  logic [NUM_SP-1:0]        serRstQ;
  logic [ADDR_W-1:0]        awAddrQ;
  logic [31:0]              wDataQ;
  logic [3:0]               wStrbQ;
  logic                     awHeldQ;
  logic                     wHeldQ;
  axil_rsp_t                rspQ;

  // Per-setpoint state views.
  logic [NUM_SP-1:0]        outVec;
  logic [NUM_SP-1:0]        pendVec;
  logic [NUM_SP-1:0]        inhVec;

  // Time base and input pins.
  logic [SW-1:0]            secCntQ;
  logic                     secTickQ;
  logic [1:0]               keySyncQ;
  logic [1:0]               uiSyncQ;
  logic                     keyPrevQ;
  logic                     uiPrevQ;
  logic                     keyEvQ;
  logic                     uiEvQ;
  logic                     colourQ;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic signed [MEAS_W-1:0] clampSp(input logic [31:0] v);
    logic signed [31:0] s;
    s = signed'(v);
    if (s < 32'(SP_MIN)) begin
      return SP_MIN;
    end
    if (s > 32'(SP_MAX)) begin
      return SP_MAX;
    end
    return s[MEAS_W-1:0];
  endfunction

  function automatic logic [HYS_W-1:0] clampHys(input logic [31:0] v);
    if (v < 32'(HYS_MIN)) begin
      return HYS_MIN;
    end
    if (v > 32'(HYS_MAX)) begin
      return HYS_MAX;
    end
    return v[HYS_W-1:0];
  endfunction

  function automatic logic [DLY_W-1:0] clampDly(input logic [31:0] v);
    if (v > 32'(DLY_MAX)) begin
      return DLY_MAX;
    end
    return v[DLY_W-1:0];
  endfunction

  // Address decode helpers.
  function automatic int spIndex(input logic [ADDR_W-1:0] a);
    if (a < SP_BASE_OFS) begin
      return -1;
    end
    return int'((a - SP_BASE_OFS) / SP_STRIDE);
  endfunction

  function automatic logic [ADDR_W-1:0] spField(input logic [ADDR_W-1:0] a);
    return (a - SP_BASE_OFS) % SP_STRIDE;
  endfunction

  // One-second time base for the delay counters.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      secCntQ  <= '0;
      secTickQ <= 1'b0;
    end else if (ce) begin
      secTickQ <= (secCntQ == SW'(SEC_CYCLES - 1));
      secCntQ  <= (secCntQ == SW'(SEC_CYCLES - 1)) ? '0 : secCntQ + 1'b1;
    end
  end

  // Front key and user input come from pins and are synchronised first.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      keySyncQ <= 2'h0;
      uiSyncQ  <= 2'h0;
      keyPrevQ <= 1'b0;
      uiPrevQ  <= 1'b0;
      keyEvQ   <= 1'b0;
      uiEvQ    <= 1'b0;
    end else if (ce) begin
      keySyncQ <= {keySyncQ[0], resetKeyPin};
      uiSyncQ  <= {uiSyncQ[0], userInputPin};
      keyPrevQ <= keySyncQ[1];
      uiPrevQ  <= uiSyncQ[1];
      keyEvQ   <= keySyncQ[1] && !keyPrevQ;
      uiEvQ    <= uiSyncQ[1] && !uiPrevQ;
    end
  end

  // Write channel: address and data are taken in either order.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      awHeldQ      <= 1'b0;
      wHeldQ       <= 1'b0;
      awAddrQ      <= '0;
      wDataQ       <= '0;
      wStrbQ       <= 4'h0;
      rspQ.awready <= 1'b1;
      rspQ.wready  <= 1'b1;
      rspQ.bvalid  <= 1'b0;
      rspQ.bresp   <= RESP_OKAY;
      ctrlQ        <= CTRL_RST;
      serRstQ      <= '0;
      for (int i = 0; i < NUM_SP; i++) begin
        cfgQ[i]    <= sp_cfg_t'(CFG_RST);
        valQ[i]    <= '0;
        hysQ[i]    <= HYS_MIN;
        onDlyQ[i]  <= '0;
        offDlyQ[i] <= '0;
      end
    end else if (ce) begin
      serRstQ <= '0;
      if (axiReq.awvalid && rspQ.awready) begin
        awAddrQ      <= axiReq.awaddr;
        awHeldQ      <= 1'b1;
        rspQ.awready <= 1'b0;
      end
      if (axiReq.wvalid && rspQ.wready) begin
        wDataQ      <= axiReq.wdata;
        wStrbQ      <= axiReq.wstrb;
        wHeldQ      <= 1'b1;
        rspQ.wready <= 1'b0;
      end
      if (awHeldQ && wHeldQ && !rspQ.bvalid) begin
        rspQ.bvalid <= 1'b1;
        rspQ.bresp  <= RESP_OKAY;
        if (awAddrQ == CTRL_OFS) begin
          ctrlQ <= 3'(merge(32'(ctrlQ), wDataQ, wStrbQ));
        end else if (awAddrQ == SER_RST_OFS) begin
          serRstQ <= wDataQ[NUM_SP-1:0];
        end else if (awAddrQ == STATUS_OFS) begin
          rspQ.bresp <= RESP_OKAY;
        end else if (spIndex(awAddrQ) >= 0 && spIndex(awAddrQ) < NUM_SP
                     && awAddrQ[1:0] == 2'h0) begin
          for (int i = 0; i < NUM_SP; i++) begin
            if (spIndex(awAddrQ) == i) begin
              unique case (spField(awAddrQ))
                CFG_OFS: cfgQ[i] <= sp_cfg_t'(
                  8'(merge(32'(cfgQ[i]), wDataQ, wStrbQ)));
                VAL_OFS: valQ[i] <= clampSp(merge(
                  32'(signed'(valQ[i])), wDataQ, wStrbQ));
                HYS_OFS: hysQ[i] <= clampHys(
                  merge(32'(hysQ[i]), wDataQ, wStrbQ));
                ON_DLY_OFS: onDlyQ[i] <= clampDly(
                  merge(32'(onDlyQ[i]), wDataQ, wStrbQ));
                OFF_DLY_OFS: offDlyQ[i] <= clampDly(
                  merge(32'(offDlyQ[i]), wDataQ, wStrbQ));
                default: rspQ.bresp <= RESP_SLVERR;
              endcase
            end
          end
        end else begin
          rspQ.bresp <= RESP_SLVERR;
        end
      end
      if (rspQ.bvalid && axiReq.bready) begin
        rspQ.bvalid  <= 1'b0;
        awHeldQ      <= 1'b0;
        wHeldQ       <= 1'b0;
        rspQ.awready <= 1'b1;
        rspQ.wready  <= 1'b1;
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rspQ.arready <= 1'b1;
      rspQ.rvalid  <= 1'b0;
      rspQ.rdata   <= '0;
      rspQ.rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (axiReq.arvalid && rspQ.arready) begin
        rspQ.arready <= 1'b0;
        rspQ.rvalid  <= 1'b1;
        rspQ.rresp   <= RESP_OKAY;
        rspQ.rdata   <= '0;
        if (axiReq.araddr == CTRL_OFS) begin
          rspQ.rdata <= 32'(ctrlQ);
        end else if (axiReq.araddr == STATUS_OFS) begin
          rspQ.rdata <= {8'h0, 8'(inhVec), 8'(pendVec), 8'(outVec)};
        end else if (axiReq.araddr == SER_RST_OFS) begin
          rspQ.rdata <= '0;
        end else if (spIndex(axiReq.araddr) >= 0
                     && spIndex(axiReq.araddr) < NUM_SP
                     && axiReq.araddr[1:0] == 2'h0) begin
          for (int i = 0; i < NUM_SP; i++) begin
            if (spIndex(axiReq.araddr) == i) begin
              unique case (spField(axiReq.araddr))
                CFG_OFS:     rspQ.rdata <= 32'(cfgQ[i]);
                VAL_OFS:     rspQ.rdata <= 32'(signed'(valQ[i]));
                HYS_OFS:     rspQ.rdata <= 32'(hysQ[i]);
                ON_DLY_OFS:  rspQ.rdata <= 32'(onDlyQ[i]);
                OFF_DLY_OFS: rspQ.rdata <= 32'(offDlyQ[i]);
                default:     rspQ.rresp <= RESP_SLVERR;
              endcase
            end
          end
        end else begin
          rspQ.rresp <= RESP_SLVERR;
        end
      end
      if (rspQ.rvalid && axiReq.rready) begin
        rspQ.rvalid  <= 1'b0;
        rspQ.arready <= 1'b1;
      end
    end
  end

  assign axiRsp = rspQ;

  // Each setpoint carries its own parameter set and state.
  for (genvar g = 0; g < NUM_SP; g++) begin : gSp
    logic                  onQ;
    logic                  blockQ;
    logic                  pendQ;
    logic                  inhQ;
    logic                  prevTripQ;
    logic [DLY_W-1:0]      onCntQ;
    logic [DLY_W-1:0]      offCntQ;
    logic signed [MEAS_W+1:0] sp;
    logic signed [MEAS_W+1:0] hys;
    logic signed [MEAS_W+1:0] half;
    logic signed [MEAS_W+1:0] meas;
    logic                  high;
    logic                  balanced;
    logic                  trip;
    logic                  release_;
    logic                  en;
    logic                  deferred;
    logic                  dispLink;
    logic                  nowRst;
    logic                  deferRst;
    logic                  offReq;

    always_comb begin
      sp       = (MEAS_W+2)'(valQ[g]);
      hys      = (MEAS_W+2)'({1'b0, hysQ[g]});
      half     = hys >>> 1;
      meas     = (MEAS_W+2)'(measValue);
      high     = cfgQ[g].action inside {high_trip_balanced,
                                        high_trip_unbalanced};
      balanced = cfgQ[g].action inside {high_trip_balanced,
                                        low_trip_balanced};
      unique case ({high, balanced})
        2'b11:   trip = meas >= sp + half;
        2'b10:   trip = meas >= sp;
        2'b01:   trip = meas <= sp - half;
        default: trip = meas <= sp;
      endcase
      unique case ({high, balanced})
        2'b11:   release_ = meas < sp - half;
        2'b10:   release_ = meas < sp - hys;
        2'b01:   release_ = meas > sp + half;
        default: release_ = meas > sp + hys;
      endcase
      en       = (g == 0) || cfgQ[g].enable;
      deferred = cfgQ[g].resetMode == latch_deferred_mode;
      dispLink = cfgQ[g].rstWithDisp && inputShown
                 && ((keyEvQ && ctrlQ[0]) || (uiEvQ && ctrlQ[1]));
      nowRst   = serRstQ[g] || dispLink
                 || ((keyEvQ || uiEvQ) && !deferred);
      deferRst = (keyEvQ || uiEvQ) && deferred && !nowRst;
      offReq   = release_ && (pendQ
                 || cfgQ[g].resetMode == automatic_mode
                 || cfgQ[g].resetMode == 2'h3);
    end

    // Power-up clears latched output and pending reset.
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        onQ       <= 1'b0;
        blockQ    <= 1'b0;
        pendQ     <= 1'b0;
        inhQ      <= 1'b1;
        // A trip already present at power-up is not a crossing.
        prevTripQ <= 1'b1;
        onCntQ    <= '0;
        offCntQ   <= '0;
      end else if (ce) begin
        prevTripQ <= trip;
        if (!en) begin
          onQ     <= 1'b0;
          blockQ  <= 1'b0;
          pendQ   <= 1'b0;
          onCntQ  <= '0;
          offCntQ <= '0;
        end else begin
          if (!trip) begin
            blockQ <= 1'b0;
          end
          if (trip && !prevTripQ) begin
            inhQ <= 1'b0;
          end
          if (trip && !onQ) begin
            if (secTickQ && onCntQ != DLY_MAX) begin
              onCntQ <= onCntQ + 1'b1;
            end
          end else begin
            onCntQ <= '0;
          end
          if (offReq && onQ) begin
            if (secTickQ && offCntQ != DLY_MAX) begin
              offCntQ <= offCntQ + 1'b1;
            end
          end else begin
            offCntQ <= '0;
          end
          if (nowRst) begin
            onQ    <= 1'b0;
            pendQ  <= 1'b0;
            blockQ <= 1'b1;
          end else if (onQ) begin
            if (deferRst) begin
              pendQ <= 1'b1;
            end
            if (offReq && offCntQ >= offDlyQ[g]) begin
              onQ   <= 1'b0;
              pendQ <= 1'b0;
            end
          end else if (trip && !blockQ && !(cfgQ[g].standby && inhQ)
                       && onCntQ >= onDlyQ[g]) begin
            onQ  <= 1'b1;
            inhQ <= 1'b0;
          end
        end
      end
    end

    assign outVec[g]  = onQ;
    assign pendVec[g] = pendQ;
    assign inhVec[g]  = inhQ;
  end

  // Colour flips from the base colour while any output with colourChange set is on.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      colourQ <= 1'b0;
    end else if (ce) begin
      colourQ <= ctrlQ[2];
      for (int i = 0; i < NUM_SP; i++) begin
        if (outVec[i] && cfgQ[i].colourChange) begin
          colourQ <= !ctrlQ[2];
        end
      end
    end
  end

  assign spOut        = outVec;
  assign backlightRed = colourQ;

endmodule // setpoint_alarm_output

//--- verif/setpoint_alarm_chk.sv
`timescale 1ns/1ps
module setpoint_alarm_chk
  import setpoint_alarm_pkg::*;
#(
  parameter int NUM_SP     = 2,
  parameter int SEC_CYCLES = 20
) (
  input wire logic                          sys_clk,
  input wire logic                          rst_n,
  input wire logic                          ce,
  input wire setpoint_alarm_pkg::axil_req_t axiReq,
  input wire setpoint_alarm_pkg::axil_rsp_t axiRsp,
  input wire logic signed [setpoint_alarm_pkg::MEAS_W-1:0] measValue,
  input wire logic                          inputShown,
  input wire logic                          resetKeyPin,
  input wire logic                          userInputPin,
  input wire logic [NUM_SP-1:0]             spOut,
  input wire logic                          backlightRed
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic wrTake;
  logic en2_q;

  assign wrTake = ce && axiReq.awvalid && axiRsp.awready
                  && axiReq.wvalid && axiRsp.wready;

  sequence wr_take_s;
    wrTake;
  endsequence
  sequence rd_take_s;
    ce && axiReq.arvalid && axiRsp.arready;
  endsequence

  // The enable is shadowed here because the checker only sees the ports.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      en2_q <= 1'b0;
    end else if (wrTake && axiReq.wstrb[0]
                 && axiReq.awaddr == SP_BASE_OFS + SP_STRIDE + CFG_OFS) begin
      en2_q <= axiReq.wdata[0];
    end
  end

  reset_clear_a: assert property (disable iff (1'b0)
    (!rst_n && ce) |=> (spOut == '0 && !axiRsp.bvalid && !axiRsp.rvalid))
    else $error("outputs not cleared by reset");
  sp2_off_a: assert property ((!en2_q && !$past(en2_q)
    && !$past(en2_q, 2) && !$past(en2_q, 3) && !$past(en2_q, 4))
    |-> !spOut[1]) else $error("second output on while disabled");
  ce_freeze_a: assert property (!ce |=> $stable(spOut) && $stable(backlightRed))
    else $error("outputs moved with clock enable low");
  wr_resp_a: assert property (wr_take_s |=> ##[0:1] axiRsp.bvalid)
    else $error("write response late");
  rd_resp_a: assert property (rd_take_s |=> axiRsp.rvalid)
    else $error("read data late");
  aw_hold_a: assert property (wr_take_s |=> !axiRsp.awready && !axiRsp.wready)
    else $error("write channel ready too early");
  ar_hold_a: assert property (rd_take_s |=> !axiRsp.arready)
    else $error("read channel ready too early");
  b_done_a: assert property ((ce && axiRsp.bvalid && axiReq.bready)
    |=> !axiRsp.bvalid) else $error("write response held too long");
  r_done_a: assert property ((ce && axiRsp.rvalid && axiReq.rready)
    |=> !axiRsp.rvalid) else $error("read data held too long");
endmodule // setpoint_alarm_chk

bind setpoint_alarm_output setpoint_alarm_chk #(
  .NUM_SP     (NUM_SP),
  .SEC_CYCLES (SEC_CYCLES)
) setpoint_alarm_chk_i (
  .sys_clk      (sys_clk),
  .rst_n        (rst_n),
  .ce           (ce),
  .axiReq       (axiReq),
  .axiRsp       (axiRsp),
  .measValue    (measValue),
  .inputShown   (inputShown),
  .resetKeyPin  (resetKeyPin),
  .userInputPin (userInputPin),
  .spOut        (spOut),
  .backlightRed (backlightRed)
);

//--- verif/panel_model.sv
`timescale 1ns/1ps
module panel_model #(
  parameter int NUM_SP = 2
) (
  input  wire logic              sys_clk,
  input  wire logic [NUM_SP-1:0] spOut,
  input  wire logic              backlightRed,
  output logic                   resetKeyPin,
  output logic                   userInputPin
);
  logic [NUM_SP-1:0] contactClosed;
  logic              lampRed;

  assign contactClosed = spOut;
  assign lampRed = backlightRed;

  initial begin
    resetKeyPin = 1'b0;
    userInputPin = 1'b0;
  end

  // A press is held four edges so the pin synchroniser cannot miss it.
  task automatic press(input bit user);
    @(posedge sys_clk);
    if (user) userInputPin <= 1'b1;
    else resetKeyPin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    userInputPin <= 1'b0;
    resetKeyPin <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
endmodule // panel_model

//--- verif/setpoint_alarm_output_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  nCompared++; \
  if ((g) !== (e)) begin \
    failCount++; \
    $display("wrong value %s exp %h got %h", nm, e, g); \
  end \
end
module setpoint_alarm_output_tb_top;
  import setpoint_alarm_pkg::*;
  localparam int SEC = 20;
  localparam logic [7:0] SP0 = SP_BASE_OFS;
  localparam logic [7:0] SP1 = SP_BASE_OFS + SP_STRIDE;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} lim_t;
  typedef struct {logic [7:0] c; int m; bit clr; logic e;} row_t;

  logic                     sys_clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     ce = 1'b1;
  logic                     inputShown = 1'b0;
  axil_req_t                axiReq = '0;
  axil_rsp_t                axiRsp;
  logic signed [MEAS_W-1:0] measValue = '0;
  logic                     resetKeyPin;
  logic                     userInputPin;
  logic [1:0]               spOut;
  logic                     backlightRed;
  logic [31:0]              rdData;
  int                       failCount = 0;
  int                       nCompared = 0;

  lim_t lims[8] = '{'{SP0 + VAL_OFS, 32'd100000, 32'd99999},
    '{SP0 + VAL_OFS, 32'hffffb1e0, 32'(SP_MIN)},
    '{SP0 + HYS_OFS, 32'd0, 32'd1}, '{SP0 + HYS_OFS, 32'd60000, 32'd59999},
    '{SP0 + ON_DLY_OFS, 32'd6000, 32'd5999}, '{SP0 + ON_DLY_OFS, 0, 0},
    '{SP0 + OFF_DLY_OFS, 32'd6000, 32'd5999}, '{SP0 + OFF_DLY_OFS, 0, 0}};
  row_t rows[16] = '{'{8'h00, 109, 1, 0}, '{8'h00, 110, 0, 1},
    '{8'h00, 90, 0, 1}, '{8'h00, 89, 0, 0}, '{8'h02, 91, 1, 0},
    '{8'h02, 90, 0, 1}, '{8'h02, 110, 0, 1}, '{8'h02, 111, 0, 0},
    '{8'h04, 99, 1, 0}, '{8'h04, 100, 0, 1}, '{8'h04, 80, 0, 1},
    '{8'h04, 79, 0, 0}, '{8'h06, 101, 1, 0}, '{8'h06, 100, 0, 1},
    '{8'h06, 120, 0, 1}, '{8'h06, 121, 0, 0}};

  always #2.5 sys_clk = ~sys_clk;

  setpoint_alarm_output #(.NUM_SP(2), .SEC_CYCLES(SEC)) setpoint_alarm_output_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .axiReq(axiReq),
    .axiRsp(axiRsp), .measValue(measValue), .inputShown(inputShown),
    .resetKeyPin(resetKeyPin), .userInputPin(userInputPin),
    .spOut(spOut), .backlightRed(backlightRed));
  panel_model #(.NUM_SP(2)) panel_model_i (
    .sys_clk(sys_clk), .spOut(spOut), .backlightRed(backlightRed),
    .resetKeyPin(resetKeyPin), .userInputPin(userInputPin));

  task automatic finishTest();
    $display("compared %0d, mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] w, logic [1:0] er);
    @(posedge sys_clk);
    axiReq.awaddr <= a;
    axiReq.wdata <= w;
    axiReq.wstrb <= 4'hf;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(posedge sys_clk);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid) begin
        axiReq.bready <= 1'b0;
        `CHK("bresp", er, axiRsp.bresp)
        return;
      end
    end
    failCount++;
    finishTest();
  endtask

  task automatic rd(logic [7:0] a, logic [1:0] er, output logic [31:0] d);
    @(posedge sys_clk);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(posedge sys_clk);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid) begin
        axiReq.rready <= 1'b0;
        d = axiRsp.rdata;
        `CHK("rresp", er, axiRsp.rresp)
        return;
      end
    end
    failCount++;
    finishTest();
  endtask

  task automatic setm(int m);
    @(posedge sys_clk);
    measValue <= m[MEAS_W-1:0];
    cyc(4);
  endtask

  task automatic ok(string nm, logic e);
    `CHK(nm, e, spOut[0])
  endtask

  task automatic prs(bit u);
    panel_model_i.press(u);
    cyc(3);
  endtask

  initial begin
    cyc(2);
    rst_n <= 1'b1;
    rd(SP0 + CFG_OFS, RESP_OKAY, rdData);
    `CHK("cfg reset", 32'h0, rdData)
    rd(SP0 + HYS_OFS, RESP_OKAY, rdData);
    `CHK("hys reset", 32'h1, rdData)
    rd(8'hfc, RESP_SLVERR, rdData);
    wr(8'hfc, 32'h5, RESP_SLVERR);
    foreach (lims[i]) begin
      wr(lims[i].a, lims[i].w, RESP_OKAY);
      rd(lims[i].a, RESP_OKAY, rdData);
      `CHK("limit", lims[i].e[17:0], rdData[17:0])
    end
    wr(SP0 + VAL_OFS, 32'd100, RESP_OKAY);
    wr(SP0 + HYS_OFS, 32'd20, RESP_OKAY);
    foreach (rows[i]) begin
      setm(rows[i].m);
      wr(SP0 + CFG_OFS, {24'h0, rows[i].c}, RESP_OKAY);
      if (rows[i].clr) wr(SER_RST_OFS, 32'h1, RESP_OKAY);
      cyc(4);
      ok("trip", rows[i].e);
    end
    setm(0);
    wr(SP0 + CFG_OFS, 32'h0, RESP_OKAY);
    wr(SP0 + ON_DLY_OFS, 32'd2, RESP_OKAY);
    wr(SP0 + OFF_DLY_OFS, 32'd3, RESP_OKAY);
    setm(200);
    cyc(11);
    ok("on early", 1'b0);
    cyc(60);
    ok("on late", 1'b1);
    measValue <= '0;
    cyc(30);
    ok("off early", 1'b1);
    cyc(60);
    ok("off late", 1'b0);
    wr(SP0 + ON_DLY_OFS, 32'd0, RESP_OKAY);
    wr(SP0 + OFF_DLY_OFS, 32'd0, RESP_OKAY);
    wr(SP0 + CFG_OFS, 32'h80, RESP_OKAY);
    setm(200);
    ok("auto on", 1'b1);
    `CHK("colour on", 1'b1, backlightRed)
    prs(1'b0);
    ok("manual off", 1'b0);
    `CHK("colour off", 1'b0, backlightRed)
    cyc(10);
    ok("stay off", 1'b0);
    setm(0);
    setm(200);
    ok("re-trip", 1'b1);
    wr(SP0 + CFG_OFS, 32'h08, RESP_OKAY);
    setm(0);
    ok("latched", 1'b1);
    prs(1'b1);
    ok("user reset", 1'b0);
    setm(200);
    ok("anew", 1'b1);
    wr(SER_RST_OFS, 32'h1, RESP_OKAY);
    cyc(3);
    ok("serial", 1'b0);
    wr(SP0 + CFG_OFS, 32'h10, RESP_OKAY);
    setm(0);
    setm(200);
    prs(1'b0);
    ok("pending", 1'b1);
    rd(STATUS_OFS, RESP_OKAY, rdData);
    `CHK("pending flag", 8'h01, rdData[15:8])
    setm(0);
    ok("deferred off", 1'b0);
    wr(CTRL_OFS, 32'h1, RESP_OKAY);
    wr(SP0 + CFG_OFS, 32'h30, RESP_OKAY);
    setm(200);
    prs(1'b0);
    ok("not shown", 1'b1);
    inputShown <= 1'b1;
    prs(1'b0);
    ok("display reset", 1'b0);
    wr(CTRL_OFS, 32'h0, RESP_OKAY);
    setm(0);
    setm(200);
    prs(1'b0);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    rd(STATUS_OFS, RESP_OKAY, rdData);
    `CHK("pending lost", 8'h00, rdData[15:8])
    wr(SP1 + VAL_OFS, 32'd100, RESP_OKAY);
    cyc(4);
    `CHK("sp2 off", 1'b0, spOut[1])
    wr(SP1 + CFG_OFS, 32'h1, RESP_OKAY);
    cyc(4);
    `CHK("sp2 on", 1'b1, spOut[1])
    wr(SP1 + CFG_OFS, 32'h0, RESP_OKAY);
    cyc(6);
    `CHK("sp2 gone", 1'b0, spOut[1])
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    wr(SP1 + CFG_OFS, 32'h41, RESP_OKAY);
    cyc(4);
    `CHK("standby held", 1'b0, spOut[1])
    rd(STATUS_OFS, RESP_OKAY, rdData);
    `CHK("inhibit flag", 8'h02, rdData[23:16])
    setm(-50);
    setm(200);
    `CHK("standby trip", 1'b1, spOut[1])
    setm(-50);
    `CHK("standby normal", 1'b0, spOut[1])
    ce <= 1'b0;
    measValue <= -18'sd100;
    cyc(3);
    ce <= 1'b1;
    cyc(2);
    wr(CTRL_OFS, 32'h4, RESP_OKAY);
    cyc(2);
    `CHK("base colour", 1'b1, backlightRed)
    finishTest();
  end
endmodule // setpoint_alarm_output_tb_top
